/* File: hdl/riv_pkg.sv */
/*
  riv_pkg: shared constants and types for the reset and interrupt
  vectoring unit. Assumes a 12-bit program counter and an 8-bit datapath.
*/
package riv_pkg;

  localparam int PC_W          = 12;
  localparam int DATA_W        = 8;
  localparam int STACK_DEPTH   = 8;
  localparam int USER_FLAG_W   = 3;

  localparam logic [11:0] RESET_VECTOR = 12'h000;
  localparam logic [11:0] IRQ_VECTOR   = 12'h008;

  // program flag register layout
  localparam int FLAG_TIMEOUT_BIT  = 7;
  localparam int FLAG_PWRDOWN_BIT  = 6;
  localparam int FLAG_USER_LSB     = 0;

  localparam logic [7:0] ACC_RST       = 8'h00;
  localparam logic [2:0] USER_FLAG_RST = 3'h0;

  // reset-cause flag values per source
  localparam logic POR_TIMEOUT = 1'b1;
  localparam logic POR_PWRDOWN = 1'b0;
  localparam logic WDT_TIMEOUT = 1'b0;
  localparam logic WDT_PWRDOWN = 1'b0;
  localparam logic EXT_TIMEOUT = 1'b1;
  localparam logic EXT_PWRDOWN = 1'b1;

  typedef enum logic [1:0] {
    CAUSE_POWER_ON,
    CAUSE_WATCHDOG,
    CAUSE_EXTERNAL
  } riv_cause_t;

endpackage

/* File: hdl/riv_ret_stack.sv */
/*
  riv_ret_stack: circular return-address stack of DEPTH entries.
  Assumes push and pop are never raised together by the owner.
*/
`timescale 1ns/100ps
module riv_ret_stack #(
  parameter int DEPTH = 8,
  parameter int AW    = 12
) (
  input  wire logic   clk,
  input  wire logic   rst,
  riv_stk_if.store    stk
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][AW-1:0] mem;
    logic [PW-1:0]            sp;
    logic [CW-1:0]            cnt;
  } riv_stk_state_t;

  riv_stk_state_t q;
  riv_stk_state_t d;

  // overflow wraps and drops the oldest entry, as a fixed-depth hardware stack does
  always_comb begin
    d = q;
    if (stk.clr) begin
      d.sp  = '0;
      d.cnt = '0;
    end else if (stk.push) begin
      d.mem[q.sp] = stk.wdata;
      d.sp        = PW'(q.sp + 1'b1);
      if (q.cnt != CW'(DEPTH))
        d.cnt = CW'(q.cnt + 1'b1);
    end else if (stk.pop) begin
      d.sp = PW'(q.sp - 1'b1);
      if (q.cnt != '0)
        d.cnt = CW'(q.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign stk.rdata = q.mem[PW'(q.sp - 1'b1)];
  assign stk.empty = (q.cnt == '0);

  a_push_then_top: assert property (@(posedge clk) disable iff (rst) // [RULE7]
    (stk.push && !stk.clr) |=> (stk.rdata == $past(stk.wdata)) && !stk.empty)
    else $error("pushed address is not on top of stack");

endmodule

/* File: hdl/riv_stk_if.sv */
/*
  riv_stk_if: link between the vectoring unit and its return-address
  stack. Assumes both ends share one clock.
*/
`timescale 1ns/100ps
interface riv_stk_if #(
  parameter int AW = 12
) ();
  logic          push;
  logic          pop;
  logic          clr;
  logic [AW-1:0] wdata;
  logic [AW-1:0] rdata;
  logic          empty;

  modport owner (output push, output pop, output clr, output wdata,
                 input rdata, input empty);
  modport store (input push, input pop, input clr, input wdata,
                 output rdata, output empty);
endinterface

/* File: hdl/riv_vector_unit.sv */
/*
  riv_vector_unit: program counter steering on reset and interrupt,
  reset-cause flags and the one-level accumulator/flag shadow buffer.
  Assumes the sequencer raises at most one of the pc control inputs
  that matter per cycle and that all inputs are synchronous to SYS_CLK.
  RST is the power-on reset; watchdog and pin resets arrive as pulses.
*/
// Contract
// [RULE1] Any reset loads pc with zero and restores all system registers to defaults.
// [RULE2] Reset vector is the single program word at address zero.
// [RULE3] Power-on reset sets timeout cause flag, clears power-down cause flag.
// [RULE4] Watchdog reset clears both timeout and power-down cause flags.
// [RULE5] External pin reset sets both timeout and power-down cause flags.
// [RULE6] Both cause flags are readable as bits of the program flag register.
// [RULE7] Serviced interrupt pushes pc on stack then fetches from address eight.
// [RULE8] Save/restore copy accumulator and flags, never the two cause flags.
// [RULE9] Shadow buffer has one level; a second save overwrites the first.
// [RULE10] Return from interrupt pops the saved pc and resumes there.
`timescale 1ns/100ps
module riv_vector_unit #(
  parameter int PC_W        = riv_pkg::PC_W,
  parameter int DATA_W      = riv_pkg::DATA_W,
  parameter int STACK_DEPTH = riv_pkg::STACK_DEPTH
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RST,
  input  wire logic              WDT_RESET,
  input  wire logic              EXT_RESET,
  input  wire logic              PC_STEP,
  input  wire logic              JUMP_EN,
  input  wire logic [PC_W-1:0]   JUMP_ADDR,
  input  wire logic              IRQ_TAKE,
  input  wire logic              RETURN_FROM_INTERRUPT_OP,
  input  wire logic              SAVE_OP,
  input  wire logic              RESTORE_OP,
  input  wire logic              ACC_WE,
  input  wire logic [DATA_W-1:0] ACC_WDATA,
  input  wire logic              FLAG_WE,
  input  wire logic [2:0]        FLAG_WDATA,
  output logic      [PC_W-1:0]   PC,
  output logic      [DATA_W-1:0] ACCUMULATOR,
  output logic      [7:0]        PROGRAM_FLAG_REGISTER,
  output logic                   IRQ_ENTRY,
  output logic                   STACK_EMPTY,
  output logic      [1:0]        LAST_RESET_CAUSE
);

  typedef struct packed {
    logic [PC_W-1:0]              pc;
    logic [DATA_W-1:0]            acc;
    logic [riv_pkg::USER_FLAG_W-1:0] uflag;
    logic                         timeout_cause_flag;
    logic                         power_down_cause_flag;
    logic [DATA_W-1:0]            shadow_acc;
    logic [riv_pkg::USER_FLAG_W-1:0] shadow_flag;
    logic                         entry;
    riv_pkg::riv_cause_t          cause;
    // high only up to the first edge after power-on release; checking aid
    logic                         first;
  } riv_state_t;

  riv_state_t q;
  riv_state_t d;

  logic soft_rst;

  riv_stk_if #(.AW(PC_W)) stk ();

  riv_ret_stack #(
    .DEPTH (STACK_DEPTH),
    .AW    (PC_W)
  ) u_stack (
    .clk (SYS_CLK),
    .rst (RST),
    .stk (stk)
  );

  assign soft_rst = WDT_RESET | EXT_RESET;

  // return address is the pc the interrupted code would have run next
  assign stk.push  = IRQ_TAKE && !soft_rst; // [RULE7]
  assign stk.pop   = RETURN_FROM_INTERRUPT_OP && !IRQ_TAKE && !soft_rst; // [RULE10]
  assign stk.clr   = soft_rst; // [RULE1]
  assign stk.wdata = q.pc;

  always_comb begin
    d       = q;
    d.entry = 1'b0;
    d.first = 1'b0;
    if (soft_rst) begin
      d.pc          = riv_pkg::RESET_VECTOR[PC_W-1:0]; // [RULE1] [RULE2]
      d.acc         = riv_pkg::ACC_RST;
      d.uflag       = riv_pkg::USER_FLAG_RST;
      d.shadow_acc  = riv_pkg::ACC_RST;
      d.shadow_flag = riv_pkg::USER_FLAG_RST;
      // watchdog outranks the pin when both fire together
      if (WDT_RESET) begin
        d.timeout_cause_flag    = riv_pkg::WDT_TIMEOUT; // [RULE4]
        d.power_down_cause_flag = riv_pkg::WDT_PWRDOWN; // [RULE4]
        d.cause                 = riv_pkg::CAUSE_WATCHDOG;
      end else begin
        d.timeout_cause_flag    = riv_pkg::EXT_TIMEOUT; // [RULE5]
        d.power_down_cause_flag = riv_pkg::EXT_PWRDOWN; // [RULE5]
        d.cause                 = riv_pkg::CAUSE_EXTERNAL;
      end
    end else begin
      // interrupt entry beats return, jump and step in the same cycle
      if (IRQ_TAKE) begin
        d.pc    = riv_pkg::IRQ_VECTOR[PC_W-1:0]; // [RULE7]
        d.entry = 1'b1;
      end else if (RETURN_FROM_INTERRUPT_OP) begin
        d.pc = stk.rdata; // [RULE10]
      end else if (JUMP_EN) begin
        d.pc = JUMP_ADDR;
      end else if (PC_STEP) begin
        d.pc = PC_W'(q.pc + 1'b1);
      end

      // cause flags are left out of both copies
      if (SAVE_OP) begin
        d.shadow_acc  = q.acc;   // [RULE8] [RULE9]
        d.shadow_flag = q.uflag; // [RULE8] [RULE9]
      end
      // a save in the same cycle wins so the buffer is never read half-updated
      if (RESTORE_OP && !SAVE_OP) begin
        d.acc   = q.shadow_acc;  // [RULE8]
        d.uflag = q.shadow_flag; // [RULE8]
      end else begin
        if (ACC_WE)
          d.acc = ACC_WDATA;
        if (FLAG_WE)
          d.uflag = FLAG_WDATA;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      q.pc                    <= riv_pkg::RESET_VECTOR[PC_W-1:0]; // [RULE1]
      q.acc                   <= riv_pkg::ACC_RST;
      q.uflag                 <= riv_pkg::USER_FLAG_RST;
      q.timeout_cause_flag    <= riv_pkg::POR_TIMEOUT; // [RULE3]
      q.power_down_cause_flag <= riv_pkg::POR_PWRDOWN; // [RULE3]
      q.shadow_acc            <= riv_pkg::ACC_RST;
      q.shadow_flag           <= riv_pkg::USER_FLAG_RST;
      q.entry                 <= 1'b0;
      q.cause                 <= riv_pkg::CAUSE_POWER_ON;
      q.first                 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    PROGRAM_FLAG_REGISTER = 8'h00;
    PROGRAM_FLAG_REGISTER[riv_pkg::FLAG_TIMEOUT_BIT] = q.timeout_cause_flag; // [RULE6]
    PROGRAM_FLAG_REGISTER[riv_pkg::FLAG_PWRDOWN_BIT] = q.power_down_cause_flag; // [RULE6]
    PROGRAM_FLAG_REGISTER[riv_pkg::FLAG_USER_LSB +: riv_pkg::USER_FLAG_W] = q.uflag;
  end

  assign PC               = q.pc;
  assign ACCUMULATOR      = q.acc;
  assign IRQ_ENTRY        = q.entry;
  assign STACK_EMPTY      = stk.empty;
  assign LAST_RESET_CAUSE = q.cause;

  a_reset_pc_zero: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE1]
    soft_rst |=> (PC == '0) && (ACCUMULATOR == riv_pkg::ACC_RST) && STACK_EMPTY)
    else $error("reset did not restart at vector zero with defaults");

  a_vector_one_word: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE2]
    (soft_rst ##1 (PC_STEP && !soft_rst && !IRQ_TAKE && !JUMP_EN
                   && !RETURN_FROM_INTERRUPT_OP)) |=> (PC == 12'h001))
    else $error("reset vector is not a single word at zero");

  a_por_cause_flags: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE3]
    q.first |-> PROGRAM_FLAG_REGISTER[7] && !PROGRAM_FLAG_REGISTER[6])
    else $error("power-on cause flags wrong");

  a_wdt_cause_flags: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE4]
    WDT_RESET |=> !PROGRAM_FLAG_REGISTER[7] && !PROGRAM_FLAG_REGISTER[6])
    else $error("watchdog cause flags wrong");

  a_ext_cause_flags: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE5]
    (EXT_RESET && !WDT_RESET) |=> PROGRAM_FLAG_REGISTER[7] && PROGRAM_FLAG_REGISTER[6])
    else $error("external cause flags wrong");

  a_cause_bits_held: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE6] [RULE8]
    !soft_rst |=> $stable(PROGRAM_FLAG_REGISTER[7:6]))
    else $error("cause flags changed without a reset");

  a_irq_vector: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE7]
    (IRQ_TAKE && !soft_rst) |=> (PC == 12'h008) && IRQ_ENTRY
      && (stk.rdata == $past(PC)))
    else $error("interrupt did not save pc and vector to eight");

  a_restore_copy: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE8]
    (RESTORE_OP && !SAVE_OP && !soft_rst) |=> (ACCUMULATOR == $past(q.shadow_acc))
      && (PROGRAM_FLAG_REGISTER[2:0] == $past(q.shadow_flag)))
    else $error("restore did not return shadow contents");

  a_one_level_save: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE9]
    (SAVE_OP && !soft_rst) |=> (q.shadow_acc == $past(ACCUMULATOR))
      && (q.shadow_flag == $past(PROGRAM_FLAG_REGISTER[2:0])))
    else $error("save did not overwrite the shadow buffer");

  a_return_resume: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE10]
    (RETURN_FROM_INTERRUPT_OP && !IRQ_TAKE && !soft_rst) |=> (PC == $past(stk.rdata)))
    else $error("return did not resume at popped address");

  a_soft_clears_shadow: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE1]
    soft_rst |=> (q.shadow_acc == riv_pkg::ACC_RST)
      && (q.shadow_flag == riv_pkg::USER_FLAG_RST))
    else $error("soft reset left the shadow buffer loaded");

  a_save_keeps_live: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE8]
    (SAVE_OP && !RESTORE_OP && !ACC_WE && !FLAG_WE && !soft_rst)
      |=> $stable(ACCUMULATOR) && $stable(PROGRAM_FLAG_REGISTER))
    else $error("save disturbed the live accumulator or flags");

  a_cause_code: assert property (@(posedge SYS_CLK) disable iff (RST) // [RULE6]
    soft_rst |=> (LAST_RESET_CAUSE == ($past(WDT_RESET) ? riv_pkg::CAUSE_WATCHDOG
                                                        : riv_pkg::CAUSE_EXTERNAL)))
    else $error("recorded reset cause does not match the source");

endmodule

/* File: tb/tb_top.sv */
/*
  tb_top: self-checking bench for riv_vector_unit, one hand-written task
  per scenario. Assumes the design files under hdl/ are compiled first.
*/
`timescale 1ns/100ps
module tb_top;
  logic                     sys_clk;
  logic                     rst;
  logic                     wdt_rst;
  logic                     ext_rst;
  logic                     pc_step;
  logic                     jump_en;
  logic [11:0]              jump_addr;
  logic                     irq_take;
  logic                     ret_op;
  logic                     save_op;
  logic                     restore_op;
  logic                     aw_en;
  logic [7:0]               aw_data;
  logic                     fw_en;
  logic [2:0]               fw_data;
  logic [11:0]              pc;
  logic [7:0]               accum;
  logic [7:0]               flags;
  logic                     irq_entry;
  logic                     stk_empty;
  logic [1:0]               cause;
  int                       fails;
  int                       n_compared;

  riv_vector_unit riv_vector_unit_inst (
    .SYS_CLK                  (sys_clk),
    .RST                      (rst),
    .WDT_RESET                (wdt_rst),
    .EXT_RESET                (ext_rst),
    .PC_STEP                  (pc_step),
    .JUMP_EN                  (jump_en),
    .JUMP_ADDR                (jump_addr),
    .IRQ_TAKE                 (irq_take),
    .RETURN_FROM_INTERRUPT_OP (ret_op),
    .SAVE_OP                  (save_op),
    .RESTORE_OP               (restore_op),
    .ACC_WE                   (aw_en),
    .ACC_WDATA                (aw_data),
    .FLAG_WE                  (fw_en),
    .FLAG_WDATA               (fw_data),
    .PC                       (pc),
    .ACCUMULATOR              (accum),
    .PROGRAM_FLAG_REGISTER    (flags),
    .IRQ_ENTRY                (irq_entry),
    .STACK_EMPTY              (stk_empty),
    .LAST_RESET_CAUSE         (cause)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // inputs move 1 ns after the edge so the design samples settled values
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic jump(input logic [11:0] a);
    jump_en = 1'b1; jump_addr = a; step(); jump_en = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [2:0] f);
    aw_en = 1'b1; aw_data = a; fw_en = 1'b1; fw_data = f; step();
    aw_en = 1'b0; fw_en = 1'b0;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1; step(); s = 1'b0;
  endtask

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // soft reset from a busy state with a pushed return address
  task automatic t_soft(input logic w, input logic e, input logic [7:0] fl,
                        input logic [1:0] cs);
    jump(12'h3A5); wr(8'h5A, 3'h5); pulse(irq_take);
    wdt_rst = w; ext_rst = e; step(); wdt_rst = 1'b0; ext_rst = 1'b0;
    chk(pc, 12'h000);
    chk(12'(accum), 12'h000);
    chk(12'(flags), 12'(fl));
    chk(12'(stk_empty), 12'h001);
    chk(12'(cause), 12'(cs));
    pulse(pc_step);
    chk(pc, 12'h001);
    $display("soft reset test done");
  endtask

  // nested entry, then two returns in reverse order
  task automatic t_irq();
    jump(12'h2C7); pulse(irq_take);
    chk(pc, 12'h008);
    chk(12'(irq_entry), 12'h001);
    chk(12'(stk_empty), 12'h000);
    pc_step = 1'b1; repeat (3) step(); pc_step = 1'b0;
    chk(12'(irq_entry), 12'h000);
    chk(pc, 12'h00B);
    // return held over the entry edge must not pop, then pops twice
    irq_take = 1'b1;
    ret_op = 1'b1;
    step();
    irq_take = 1'b0;
    chk(pc, 12'h008);
    step();
    chk(pc, 12'h00B);
    step();
    ret_op = 1'b0;
    chk(pc, 12'h2C7);
    chk(12'(stk_empty), 12'h001);
    $display("interrupt test done");
  endtask

  // second save replaces the first; cause bits never follow the copy
  task automatic t_shadow(input logic [1:0] top);
    wr(8'h3C, 3'h6); pulse(save_op);
    wr(8'hA1, 3'h1); pulse(save_op);
    wr(8'h00, 3'h0); pulse(restore_op);
    chk(12'(accum), 12'h0A1);
    chk(12'(flags), 12'({top, 6'h01}));
    // one level: a second restore brings back the same, not the older save
    wr(8'h00, 3'h0);
    pulse(restore_op);
    chk(12'(accum), 12'h0A1);
    $display("shadow test done");
  endtask

  task automatic t_por();
    jump(12'h123); wr(8'h77, 3'h7); pulse(irq_take);
    rst = 1'b1; step(); step(); rst = 1'b0;
    chk(pc, 12'h000);
    chk(12'(accum), 12'h000);
    chk(12'(flags), 12'h080);
    chk(12'(stk_empty), 12'h001);
    chk(12'(cause), 12'h000);
    $display("power-on reset test done");
  endtask

  initial begin
    fails = 0; n_compared = 0;
    rst = 1'b1; wdt_rst = 1'b0; ext_rst = 1'b0; pc_step = 1'b0;
    jump_en = 1'b0; jump_addr = 12'h000; irq_take = 1'b0; ret_op = 1'b0;
    save_op = 1'b0; restore_op = 1'b0; aw_en = 1'b0; aw_data = 8'h00;
    fw_en = 1'b0; fw_data = 3'h0;
    repeat (8) @(posedge sys_clk);
    #1 rst = 1'b0;
    chk(12'(flags), 12'h080);
    t_irq();
    t_shadow(2'h2);
    t_soft(1'b1, 1'b0, 8'h00, 2'h1);
    t_soft(1'b0, 1'b1, 8'hC0, 2'h2);
    t_shadow(2'h3);
    t_soft(1'b1, 1'b1, 8'h00, 2'h1);
    t_por();
    // requests start at the first edge after the mid-run release
    t_irq();
    stop_test();
  end

  // whole run is near 60 cycles; this bound is generous
  initial begin
    #20000;
    fails++;
    stop_test();
  end
endmodule
